// *** pkg/bus_release_pkg.sv ***
// Package: shared types and constants for bus release and nonmaskable interrupt control
package bus_release_pkg;
	localparam int ADDR_W        = 24;
	localparam int DATA_W        = 8;
	localparam logic STROBE_IDLE = 1'b1;

	// Memory interface as driven by the core
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic              data_oe;
		logic              io_request_n;
		logic              memory_request_n;
		logic              fetch_indicator_n;
	} mem_bus_s;

	// Address and strobes seen on the pins while the bus is granted
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic              io_request_n;
		logic              memory_request_n;
	} snoop_s;

	typedef enum logic [1:0] {
		ST_OWNED,
		ST_RELEASE,
		ST_GRANTED,
		ST_RECLAIM
	} grant_state_e;
endpackage : bus_release_pkg

// *** src/bus_release_nmi_ctrl.sv ***
// Bus release handshake and nonmaskable interrupt capture for the memory interface
module bus_release_nmi_ctrl
	import bus_release_pkg::*;
(
	// Clock and reset
	input  wire logic              sys_clk,
	input  wire logic              rst,
	// Core side
	input  wire mem_bus_s          core_bus,
	input  wire logic              instr_end,
	input  wire logic              maskable_pending,
	output logic                   take_nmi,
	output logic                   take_maskable,
	output logic                   bus_granted,
	output snoop_s                 snoop,
	// Pins
	input  wire logic              nmi_n,
	input  wire logic              bus_release_request_n,
	output logic                   bus_release_grant_n,
	input  wire logic [ADDR_W-1:0] addr_i,
	output logic [ADDR_W-1:0]      addr_o,
	output logic                   addr_oe,
	output logic [DATA_W-1:0]      data_o,
	output logic                   data_oe,
	input  wire logic              io_request_n_i,
	output logic                   io_request_n_o,
	input  wire logic              memory_request_n_i,
	output logic                   memory_request_n_o,
	output logic                   ctrl_oe,
	output logic                   fetch_indicator_n_o,
	output logic                   fetch_indicator_n_oe
);
	grant_state_e state_q;
	logic         nmi_prev_q;
	logic         nmi_pend_q;
	logic         nmi_fall;

	// Falling edge of the active low interrupt pin
	assign nmi_fall = nmi_prev_q & ~nmi_n;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			nmi_prev_q <= 1'b1;
		end else begin
			nmi_prev_q <= nmi_n;
		end
	end

	// Pending flag: a new edge wins over the clear
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			nmi_pend_q <= 1'b0;
		end else if (nmi_fall) begin
			nmi_pend_q <= 1'b1;
		end else if (take_nmi) begin
			nmi_pend_q <= 1'b0;
		end
	end

	// Interrupt acceptance at instruction boundary, no enable gating
	assign take_nmi      = instr_end & nmi_pend_q;
	assign take_maskable = instr_end & maskable_pending & ~nmi_pend_q;

	// Interrupt checks
	sequence s_nmi_fall;
		nmi_prev_q && !nmi_n;
	endsequence

	chk_nmi_edge: assert property (@(posedge sys_clk) disable iff (rst)
		nmi_prev_q && !nmi_n |=> nmi_pend_q)
		else $error("falling edge not captured");
	chk_nmi_level: assert property (@(posedge sys_clk) disable iff (rst)
		take_nmi && !nmi_fall |=> !nmi_pend_q)
		else $error("held low level retriggered interrupt");
	chk_nmi_first: assert property (@(posedge sys_clk) disable iff (rst)
		nmi_pend_q && instr_end |-> take_nmi && !take_maskable)
		else $error("maskable served ahead of nonmaskable");
	chk_nmi_boundary: assert property (@(posedge sys_clk) disable iff (rst)
		take_nmi |-> instr_end)
		else $error("nonmaskable taken off boundary");
	chk_edge_then_take: assert property (@(posedge sys_clk) disable iff (rst)
		s_nmi_fall ##1 instr_end |-> take_nmi)
		else $error("captured edge not taken at next boundary");
	chk_pend_held: assert property (@(posedge sys_clk) disable iff (rst)
		nmi_pend_q && !instr_end |=> nmi_pend_q)
		else $error("pending interrupt lost before a boundary");
	chk_no_spurious: assert property (@(posedge sys_clk) disable iff (rst)
		!nmi_pend_q && !nmi_fall |=> !nmi_pend_q)
		else $error("interrupt pending without a falling edge");
	chk_mask_alone: assert property (@(posedge sys_clk) disable iff (rst)
		instr_end && maskable_pending && !nmi_pend_q |-> take_maskable)
		else $error("maskable not taken with no nonmaskable pending");
	chk_one_take: assert property (@(posedge sys_clk) disable iff (rst)
		!(take_nmi && take_maskable))
		else $error("both interrupts taken together");
	chk_mask_boundary: assert property (@(posedge sys_clk) disable iff (rst)
		take_maskable |-> instr_end)
		else $error("maskable taken off boundary");

	// Grant handshake: release a cycle, then grant; drop grant a cycle before driving
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_q <= ST_OWNED;
		end else begin
			case (state_q)
				ST_OWNED:   if (!bus_release_request_n) state_q <= ST_RELEASE;
				ST_RELEASE: state_q <= ST_GRANTED;
				ST_GRANTED: if (bus_release_request_n) state_q <= ST_RECLAIM;
				ST_RECLAIM: state_q <= ST_OWNED;
				default:    state_q <= ST_OWNED;
			endcase
		end
	end

	// Grant pin from a flip-flop
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			bus_release_grant_n <= 1'b1;
		end else begin
			bus_release_grant_n <= ~((state_q == ST_RELEASE) ||
				(state_q == ST_GRANTED && !bus_release_request_n));
		end
	end

	// Output data registered from the core
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			addr_o              <= '0;
			data_o              <= '0;
			io_request_n_o      <= STROBE_IDLE;
			memory_request_n_o  <= STROBE_IDLE;
			fetch_indicator_n_o <= STROBE_IDLE;
		end else begin
			addr_o              <= core_bus.addr;
			data_o              <= core_bus.data;
			io_request_n_o      <= core_bus.io_request_n;
			memory_request_n_o  <= core_bus.memory_request_n;
			fetch_indicator_n_o <= core_bus.fetch_indicator_n;
		end
	end

	// Drivers enabled only while the core owns the bus
	assign bus_granted          = (state_q != ST_OWNED);
	assign addr_oe              = ~bus_granted;
	assign ctrl_oe              = ~bus_granted;
	assign data_oe              = ~bus_granted & core_bus.data_oe;
	assign fetch_indicator_n_oe = ~bus_granted;

	// Pins read as inputs while granted; strobes held idle while the core drives them
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			snoop.addr             <= '0;
			snoop.io_request_n     <= STROBE_IDLE;
			snoop.memory_request_n <= STROBE_IDLE;
		end else begin
			snoop.addr             <= addr_i;
			snoop.io_request_n     <= bus_granted ? io_request_n_i : STROBE_IDLE;
			snoop.memory_request_n <= bus_granted ? memory_request_n_i : STROBE_IDLE;
		end
	end

	// Bus handshake checks
	sequence s_req_held;
		!bus_release_request_n [*2];
	endsequence

	sequence s_take;
		state_q == ST_OWNED && !bus_release_request_n;
	endsequence

	sequence s_floated;
		!addr_oe && !ctrl_oe && !data_oe && !fetch_indicator_n_oe;
	endsequence

	sequence s_drop;
		state_q == ST_GRANTED && bus_release_request_n;
	endsequence

	sequence s_driving;
		addr_oe && ctrl_oe && fetch_indicator_n_oe;
	endsequence

	chk_release_before_grant: assert property (@(posedge sys_clk) disable iff (rst)
		$fell(bus_release_grant_n) |-> !addr_oe && !ctrl_oe && !data_oe)
		else $error("grant given while bus still driven");
	chk_grant_after_req: assert property (@(posedge sys_clk) disable iff (rst)
		(state_q == ST_OWNED) ##0 s_req_held ##1 !bus_release_request_n |-> !bus_release_grant_n)
		else $error("grant not given two cycles after request");
	chk_fetch_float: assert property (@(posedge sys_clk) disable iff (rst)
		!bus_release_grant_n |-> !fetch_indicator_n_oe)
		else $error("fetch indicator driven during grant");
	chk_strobe_input: assert property (@(posedge sys_clk) disable iff (rst)
		!bus_release_grant_n |-> snoop.memory_request_n == $past(memory_request_n_i))
		else $error("strobe not taken from pins during grant");
	chk_drop_then_drive: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(bus_release_grant_n) |-> !addr_oe ##1 addr_oe)
		else $error("bus not reclaimed one cycle after grant drop");

	// Whole walks: float one cycle after the take, grant one cycle later; drop, then drive
	chk_take_walk: assert property (@(posedge sys_clk) disable iff (rst)
		s_take |=> s_floated ##1 (!bus_release_grant_n && bus_granted))
		else $error("release walk out of step");
	chk_reclaim_walk: assert property (@(posedge sys_clk) disable iff (rst)
		s_drop |=> (bus_release_grant_n && !addr_oe) ##1 s_driving)
		else $error("reclaim walk out of step");
	chk_grant_stands: assert property (@(posedge sys_clk) disable iff (rst)
		state_q == ST_GRANTED && !bus_release_request_n |=> !bus_release_grant_n && !addr_oe)
		else $error("grant lost while request held");
	chk_owned_no_grant: assert property (@(posedge sys_clk) disable iff (rst)
		state_q == ST_OWNED |-> bus_release_grant_n)
		else $error("grant shown while core owns the bus");
	chk_float_granted: assert property (@(posedge sys_clk) disable iff (rst)
		bus_granted |-> !addr_oe && !ctrl_oe && !data_oe)
		else $error("bus driven while granted");
	chk_fetch_back: assert property (@(posedge sys_clk) disable iff (rst)
		!bus_granted |-> fetch_indicator_n_oe)
		else $error("fetch indicator floating while owned");

	// Pin sampling checks
	chk_idle_snoop: assert property (@(posedge sys_clk) disable iff (rst)
		!bus_granted |=> snoop.io_request_n && snoop.memory_request_n)
		else $error("pin strobes passed through while owned");
	chk_io_snoop: assert property (@(posedge sys_clk) disable iff (rst)
		!bus_release_grant_n |-> snoop.io_request_n == $past(io_request_n_i))
		else $error("io strobe not taken from pins during grant");
	chk_addr_snoop: assert property (@(posedge sys_clk) disable iff (rst)
		bus_granted |=> snoop.addr == $past(addr_i))
		else $error("address not taken from pins during grant");
endmodule : bus_release_nmi_ctrl

// *** testbench/ext_master.sv ***
// Outside bus master model that borrows the memory interface
module ext_master
	import bus_release_pkg::*;
(
	// Bench control
	input  wire logic              sys_clk,
	input  wire logic              want,
	input  wire logic [ADDR_W-1:0] want_addr,
	// Pins
	input  wire logic              bus_release_grant_n,
	output logic                   bus_release_request_n,
	output snoop_s                 pins
);
	timeunit 1ns;
	timeprecision 1ns;
	logic drive_q;
	// Idle at time zero
	initial begin
		bus_release_request_n = 1'b1;
		drive_q = 1'b0;
		pins = '0;
	end
	// Request follows the bench, driving only while granted and wanted
	always @(posedge sys_clk) begin
		bus_release_request_n <= #5 !want;
		drive_q <= #5 want && !bus_release_grant_n;
	end
	// Undriven lines toggle so no stale value passes
	always @(posedge sys_clk) pins <= #5 drive_q ? {want_addr, 2'b10} : ~pins;
endmodule : ext_master

// *** testbench/testbench.sv ***
// Self-checking bench for bus release and nonmaskable interrupt control
module testbench;
	import bus_release_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 1'b0, rst = 1'b1, instr_end = 1'b0, maskable_pending = 1'b0;
	logic nmi_n = 1'b1, want = 1'b0, take_nmi, take_maskable, grant_n, req_n;
	logic addr_oe, data_oe, ctrl_oe, fi_oe;
	logic io_out, mem_out, fi_out, granted;
	logic [DATA_W-1:0] data_out;
	logic [ADDR_W-1:0] addr_out;
	logic [ADDR_W-1:0] want_addr = '0;
	mem_bus_s core_bus = '0;
	mem_bus_s exp_bus;
	mem_bus_s hist[$];
	snoop_s snoop, pins;
	int num_errors = 0, tests_run = 0, cycles = 0, pend = 0, prev = 1;
	logic [31:0] r, r2;
	logic [31:0] seed = 32'h698CF2B6;
	bus_release_nmi_ctrl i_bus_release_nmi_ctrl (.sys_clk(sys_clk), .rst(rst),
		.core_bus(core_bus), .instr_end(instr_end), .maskable_pending(maskable_pending),
		.take_nmi(take_nmi), .take_maskable(take_maskable), .bus_granted(granted), .snoop(snoop),
		.nmi_n(nmi_n), .bus_release_request_n(req_n), .bus_release_grant_n(grant_n),
		.addr_i(pins.addr), .addr_o(addr_out), .addr_oe(addr_oe), .data_o(data_out),
		.data_oe(data_oe), .io_request_n_i(pins.io_request_n), .io_request_n_o(io_out),
		.memory_request_n_i(pins.memory_request_n), .memory_request_n_o(mem_out),
		.ctrl_oe(ctrl_oe), .fetch_indicator_n_o(fi_out), .fetch_indicator_n_oe(fi_oe));
	ext_master i_ext_master (.sys_clk(sys_clk), .want(want), .want_addr(want_addr),
		.bus_release_grant_n(grant_n), .bus_release_request_n(req_n), .pins(pins));
	// Clock
	initial begin
		forever #25 sys_clk = ~sys_clk;
	end
	// Cut a hang short
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles > 500) begin
			num_errors++;
			complete_run();
		end
	end
	task automatic chk(string n, logic [31:0] e, logic [31:0] s);
		tests_run++;
		if (e !== s) begin
			$display("mismatch %s expected %h seen %h", n, e, s);
			num_errors++;
		end
	endtask : chk
	task automatic step(int n);
		repeat (n) @(posedge sys_clk);
		#5;
	endtask : step
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : complete_run
	// Main sequence
	initial begin
		// Registered pin outputs start from zero address and data, idle strobes
		exp_bus = '0;
		{exp_bus.io_request_n, exp_bus.memory_request_n,
			exp_bus.fetch_indicator_n} = {3{STROBE_IDLE}};
		hist.push_back(exp_bus);
		step(6);
		rst = 1'b0;
		// Random interrupt traffic against an edge-capture model
		for (int i = 0; i < 40; i++) begin
			r = $random(seed);
			r2 = $random(seed);
			{nmi_n, instr_end, maskable_pending} = r[2:0];
			core_bus = {r[31:28], r2};
			#1;
			chk("take_nmi", 32'(instr_end && pend), 32'(take_nmi));
			chk("take_maskable", 32'(instr_end && maskable_pending && !pend),
				32'(take_maskable));
			exp_bus = hist.pop_front();
			chk("addr_data out", {exp_bus.addr, exp_bus.data}, {addr_out, data_out});
			chk("strobes out", 32'({exp_bus.io_request_n, exp_bus.memory_request_n,
				exp_bus.fetch_indicator_n}), 32'({io_out, mem_out, fi_out}));
			chk("oe owned", 32'({2'b11, core_bus.data_oe, 1'b1}),
				32'({addr_oe, ctrl_oe, data_oe, fi_oe}));
			chk("snoop idle", 3, 32'({snoop.io_request_n, snoop.memory_request_n}));
			hist.push_back(core_bus);
			@(posedge sys_clk);
			pend = int'((prev && !nmi_n) || (pend && !instr_end));
			prev = nmi_n;
			#5;
		end
		$display("interrupt test done");
		// Lend the bus to the outside master and take it back
		want_addr = r2[23:0];
		core_bus.data_oe = 1'b1;
		want = 1'b1;
		step(2);
		chk("grant_n early", 1, 32'(grant_n));
		chk("oe released", 1, 32'({addr_oe, data_oe, ctrl_oe, fi_oe, granted}));
		step(1);
		chk("grant_n", 0, 32'(grant_n));
		step(3);
		chk("snoop", 32'({want_addr, 2'b10}), 32'(snoop));
		want = 1'b0;
		step(2);
		chk("grant_n back", 2, 32'({grant_n, addr_oe}));
		step(1);
		chk("oe back", 2, 32'({addr_oe, granted}));
		// A one-cycle request still earns a full release, grant and reclaim
		want = 1'b1;
		step(1);
		want = 1'b0;
		step(1);
		chk("pulse oe", 1, 32'({addr_oe, granted}));
		step(1);
		chk("pulse grant_n", 0, 32'(grant_n));
		step(1);
		chk("pulse drop", 2, 32'({grant_n, addr_oe}));
		step(1);
		chk("pulse back", 2, 32'({addr_oe, granted}));
		$display("bus release test done");
		complete_run();
	end
endmodule : testbench
